// *** hw/art_edge_sync.sv ***
// Two-flop synchroniser with rising-edge pulse for an asynchronous level.
// Assumes the level is slow against the system clock.
`timescale 1ns/100ps
module art_edge_sync (
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	input  wire logic async_i,
	output logic      rise_o
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// Only sync_q reads meta_q; the edge detector looks at sync_q and last_q
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign rise_o = sync_q & ~last_q;
endmodule : art_edge_sync

// *** hw/art_pkg.sv ***
// Package for the auto-reload timer with comparator capture.
// Assumes a byte-wide special-function register port on one system clock.
package art_pkg;
	localparam logic [7:0] ADDR_CTRL     = 8'h91;
	localparam logic [7:0] ADDR_RELOAD_L = 8'h92;
	localparam logic [7:0] ADDR_RELOAD_H = 8'h93;
	localparam logic [7:0] ADDR_COUNT_L  = 8'h94;
	localparam logic [7:0] ADDR_COUNT_H  = 8'h95;

	localparam int BIT_HIGH_FLAG   = 7;
	localparam int BIT_LOW_FLAG    = 6;
	localparam int BIT_LOW_IRQ_EN  = 5;
	localparam int BIT_CAPTURE_EN  = 4;
	localparam int BIT_SPLIT       = 3;
	localparam int BIT_RUN         = 2;
	localparam int BIT_EXT_CLK_SEL = 0;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
	localparam logic [7:0] BYTE_ONE      = 8'h01;
endpackage : art_pkg

// *** hw/art_timer.sv ***
// Auto-reload timer with comparator capture and split 8-bit mode.
// Assumes count enables arrive as one-cycle pulses on core_clk_i and the
// comparator output is asynchronous.
//
// Functional notes
// - Comparator capture copies 16-bit count into both reload bytes on rising edge.
// - Capture with timer interrupts enabled raises an interrupt request.
// - Split bit 0 gives one 16-bit counter, 1 gives two 8-bit counters.
// - In 16-bit mode the timer counts only while run control is 1.
// - In split mode run gates only the high byte; low byte always counts.
// - Low reload byte supplies the low byte on auto-reload.
// - High reload byte supplies the high byte on auto-reload.
// - High overflow flag set on high byte wrap; software clears it.
// - Low overflow flag set on every low byte wrap; software clears it.
// - High count byte shows upper count half or independent high counter.
// - Low overflow with low enable and timer interrupts enabled requests interrupt.
`timescale 1ns/100ps
module art_timer (
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic       sfr_wr_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       sfr_rd_i,
	input  wire logic       sys_tick_i,
	input  wire logic       ext_tick_i,
	input  wire logic       timer_irq_en_i,
	input  wire logic       analog_comparator_output_i,
	output logic      [7:0] sfr_rdata_o,
	output logic            irq_o
);
	logic [7:0] ctrl_q;
	logic [7:0] reload_low_byte_q;
	logic [7:0] reload_high_byte_q;
	logic [7:0] count_low_byte_q;
	logic [7:0] count_high_byte_q;
	logic [7:0] count_low_byte_d;
	logic [7:0] count_high_byte_d;
	logic [7:0] sfr_rdata_q;
	logic       irq_q;
	logic       high_overflow_flag_q;
	logic       low_overflow_flag_q;
	logic       cmp_rise;
	logic       capture_evt;
	logic       tick;
	logic       lo_tick;
	logic       hi_tick;
	logic       lo_wrap;
	logic       hi_wrap;
	logic       wr_ctrl;
	logic       wr_rl;
	logic       wr_rh;
	logic       wr_cl;
	logic       wr_ch;
	logic       split_mode_enable;
	logic       run_control;
	logic       comparator_capture_enable;
	logic       low_overflow_irq_enable;

	art_edge_sync u_cmp_sync (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.async_i    (analog_comparator_output_i),
		.rise_o     (cmp_rise)
	);

	assign split_mode_enable         = ctrl_q[art_pkg::BIT_SPLIT];
	assign run_control               = ctrl_q[art_pkg::BIT_RUN];
	assign comparator_capture_enable = ctrl_q[art_pkg::BIT_CAPTURE_EN];
	assign low_overflow_irq_enable   = ctrl_q[art_pkg::BIT_LOW_IRQ_EN];
	assign wr_ctrl = sfr_wr_i && (sfr_addr_i == art_pkg::ADDR_CTRL);
	assign wr_rl   = sfr_wr_i && (sfr_addr_i == art_pkg::ADDR_RELOAD_L);
	assign wr_rh   = sfr_wr_i && (sfr_addr_i == art_pkg::ADDR_RELOAD_H);
	assign wr_cl   = sfr_wr_i && (sfr_addr_i == art_pkg::ADDR_COUNT_L);
	assign wr_ch   = sfr_wr_i && (sfr_addr_i == art_pkg::ADDR_COUNT_H);
	assign capture_evt = cmp_rise & comparator_capture_enable;

	// Clock source select only chooses which enable pulse advances the count
	assign tick = ctrl_q[art_pkg::BIT_EXT_CLK_SEL] ? ext_tick_i : sys_tick_i;

	always_comb begin
		lo_tick = split_mode_enable ? tick : (tick & run_control);
		hi_tick = split_mode_enable ? (tick & run_control)
			: (tick & run_control & (count_low_byte_q == art_pkg::BYTE_ALL_ONES));
		lo_wrap = lo_tick & (count_low_byte_q == art_pkg::BYTE_ALL_ONES);
		hi_wrap = hi_tick & (count_high_byte_q == art_pkg::BYTE_ALL_ONES);
		count_low_byte_d  = count_low_byte_q;
		count_high_byte_d = count_high_byte_q;
		if (wr_cl) begin
			count_low_byte_d = sfr_wdata_i;
		end else if (split_mode_enable ? lo_wrap : hi_wrap) begin
			count_low_byte_d = reload_low_byte_q;
		end else if (lo_tick) begin
			count_low_byte_d = count_low_byte_q + art_pkg::BYTE_ONE;
		end
		if (wr_ch) begin
			count_high_byte_d = sfr_wdata_i;
		end else if (hi_wrap) begin
			count_high_byte_d = reload_high_byte_q;
		end else if (hi_tick) begin
			count_high_byte_d = count_high_byte_q + art_pkg::BYTE_ONE;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_low_byte_q  <= art_pkg::RESET_BYTE;
			count_high_byte_q <= art_pkg::RESET_BYTE;
		end else begin
			count_low_byte_q  <= count_low_byte_d;
			count_high_byte_q <= count_high_byte_d;
		end
	end

	// Capture beats a same-cycle software write so no comparator edge is lost
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reload_low_byte_q  <= art_pkg::RESET_BYTE;
			reload_high_byte_q <= art_pkg::RESET_BYTE;
		end else if (capture_evt) begin
			reload_low_byte_q  <= count_low_byte_q;
			reload_high_byte_q <= count_high_byte_q;
		end else begin
			if (wr_rl) begin
				reload_low_byte_q <= sfr_wdata_i;
			end
			if (wr_rh) begin
				reload_high_byte_q <= sfr_wdata_i;
			end
		end
	end

	// Control bits; flag bits live in their own flops
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= art_pkg::RESET_BYTE;
		end else if (wr_ctrl) begin
			ctrl_q <= sfr_wdata_i & 8'h3D;
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			high_overflow_flag_q <= 1'b0;
			low_overflow_flag_q  <= 1'b0;
		end else begin
			if (hi_wrap) begin
				high_overflow_flag_q <= 1'b1;
			end else if (wr_ctrl) begin
				high_overflow_flag_q <= sfr_wdata_i[art_pkg::BIT_HIGH_FLAG];
			end
			if (lo_wrap) begin
				low_overflow_flag_q <= 1'b1;
			end else if (wr_ctrl) begin
				low_overflow_flag_q <= sfr_wdata_i[art_pkg::BIT_LOW_FLAG];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= timer_irq_en_i & (high_overflow_flag_q | capture_evt
				| (low_overflow_flag_q & low_overflow_irq_enable));
		end
	end

	// Read data is registered; unmapped addresses read zero
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sfr_rdata_q <= art_pkg::RESET_BYTE;
		end else if (sfr_rd_i) begin
			unique case (sfr_addr_i)
				art_pkg::ADDR_CTRL: sfr_rdata_q <= {high_overflow_flag_q,
					low_overflow_flag_q, ctrl_q[5:0]};
				art_pkg::ADDR_RELOAD_L: sfr_rdata_q <= reload_low_byte_q;
				art_pkg::ADDR_RELOAD_H: sfr_rdata_q <= reload_high_byte_q;
				art_pkg::ADDR_COUNT_L:  sfr_rdata_q <= count_low_byte_q;
				art_pkg::ADDR_COUNT_H:  sfr_rdata_q <= count_high_byte_q;
				default:                sfr_rdata_q <= art_pkg::RESET_BYTE;
			endcase
		end
	end

	assign sfr_rdata_o = sfr_rdata_q;
	assign irq_o       = irq_q;

	property p_capture_copy;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		capture_evt |=> (reload_low_byte_q == $past(count_low_byte_q))
			&& (reload_high_byte_q == $past(count_high_byte_q));
	endproperty
	a_capture_copy: assert property (p_capture_copy)
		else $error("capture did not copy count");

	property p_capture_irq;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(capture_evt && timer_irq_en_i) |=> irq_o;
	endproperty
	a_capture_irq: assert property (p_capture_irq)
		else $error("capture raised no interrupt");

	property p_reload16;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(!split_mode_enable && hi_wrap && !sfr_wr_i) |=>
			{count_high_byte_q, count_low_byte_q}
			== {$past(reload_high_byte_q), $past(reload_low_byte_q)};
	endproperty
	a_reload16: assert property (p_reload16)
		else $error("16-bit reload wrong");

	property p_stopped;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(!run_control && !split_mode_enable && !sfr_wr_i) |=>
			$stable({count_high_byte_q, count_low_byte_q});
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("count moved while stopped");

	property p_split_high_gate;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(split_mode_enable && !run_control && !sfr_wr_i) |=> $stable(count_high_byte_q);
	endproperty
	a_split_high_gate: assert property (p_split_high_gate)
		else $error("high byte moved while stopped in split mode");

	property p_split_low_free;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(split_mode_enable && tick && !sfr_wr_i
			&& count_low_byte_q != art_pkg::BYTE_ALL_ONES)
		|=> count_low_byte_q == $past(count_low_byte_q) + art_pkg::BYTE_ONE;
	endproperty
	a_split_low_free: assert property (p_split_low_free)
		else $error("split low byte did not count");

	property p_split_low_reload;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(split_mode_enable && lo_wrap && !sfr_wr_i)
		|=> count_low_byte_q == $past(reload_low_byte_q);
	endproperty
	a_split_low_reload: assert property (p_split_low_reload)
		else $error("low byte reload wrong");

	property p_split_high_reload;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(split_mode_enable && hi_wrap && !sfr_wr_i)
		|=> count_high_byte_q == $past(reload_high_byte_q);
	endproperty
	a_split_high_reload: assert property (p_split_high_reload)
		else $error("high byte reload wrong");

	property p_high_flag;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		hi_wrap |=> high_overflow_flag_q ##1 (high_overflow_flag_q || $past(wr_ctrl));
	endproperty
	a_high_flag: assert property (p_high_flag)
		else $error("high flag not set");

	property p_low_flag;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		lo_wrap |=> low_overflow_flag_q;
	endproperty
	a_low_flag: assert property (p_low_flag)
		else $error("low flag not set");

	property p_read_high;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(sfr_rd_i && sfr_addr_i == art_pkg::ADDR_COUNT_H)
		|=> sfr_rdata_o == $past(count_high_byte_q);
	endproperty
	a_read_high: assert property (p_read_high)
		else $error("high count read wrong");

	property p_low_irq;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(low_overflow_flag_q && low_overflow_irq_enable && timer_irq_en_i) |=> irq_o;
	endproperty
	a_low_irq: assert property (p_low_irq)
		else $error("low overflow raised no interrupt");

	c_capture:  cover property (@(posedge core_clk_i) disable iff (!rst_n_i) capture_evt);
	c_wrap16:   cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!split_mode_enable && hi_wrap);
	c_split_lo: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		split_mode_enable && lo_wrap && !run_control);
endmodule : art_timer

// *** verification/tb.sv ***
// Self-checking testbench for the auto-reload timer with comparator capture.
// Assumes one 200 MHz clock; the bench drives every port and reaches registers by strobes.
`timescale 1ns/100ps
module tb;
	logic       core_clk_i                 = 1'b0;
	logic       rst_n_i                    = 1'b0;
	logic [7:0] sfr_addr_i                 = 8'h00;
	logic       sfr_wr_i                   = 1'b0;
	logic [7:0] sfr_wdata_i                = 8'h00;
	logic       sfr_rd_i                   = 1'b0;
	logic       sys_tick_i                 = 1'b0;
	logic       ext_tick_i                 = 1'b0;
	logic       timer_irq_en_i             = 1'b0;
	logic       analog_comparator_output_i = 1'b0;
	logic [7:0] sfr_rdata_o;
	logic       irq_o;
	logic       irq_seen                   = 1'b0;
	int         failures                   = 0;
	int         checked                    = 0;
	int         cycles                     = 0;

	art_timer u_art_timer (
		.core_clk_i                 (core_clk_i),
		.rst_n_i                    (rst_n_i),
		.sfr_addr_i                 (sfr_addr_i),
		.sfr_wr_i                   (sfr_wr_i),
		.sfr_wdata_i                (sfr_wdata_i),
		.sfr_rd_i                   (sfr_rd_i),
		.sys_tick_i                 (sys_tick_i),
		.ext_tick_i                 (ext_tick_i),
		.timer_irq_en_i             (timer_irq_en_i),
		.analog_comparator_output_i (analog_comparator_output_i),
		.sfr_rdata_o                (sfr_rdata_o),
		.irq_o                      (irq_o)
	);

	always #2.5 core_clk_i = ~core_clk_i;

	// Capture interrupt is only a one-cycle pulse, so it is latched here
	always @(posedge core_clk_i) begin
		cycles++;
		if (irq_o === 1'b1) irq_seen = 1'b1;
		if (cycles == 20000) begin
			failures++;
			end_of_test();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge core_clk_i) #1;
		sfr_addr_i  = addr;
		sfr_wdata_i = data;
		sfr_wr_i    = 1'b1;
		@(posedge core_clk_i) #1;
		sfr_wr_i    = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string msg);
		@(posedge core_clk_i) #1;
		sfr_addr_i = addr;
		sfr_rd_i   = 1'b1;
		@(posedge core_clk_i) #1;
		sfr_rd_i   = 1'b0;
		chk(sfr_rdata_o, exp, msg);
	endtask : rd

	task automatic tick(input bit ext);
		@(posedge core_clk_i) #1;
		if (ext) ext_tick_i = 1'b1;
		else sys_tick_i = 1'b1;
		@(posedge core_clk_i) #1;
		ext_tick_i = 1'b0;
		sys_tick_i = 1'b0;
	endtask : tick

	task automatic chk_irq(input logic exp);
		repeat (3) @(posedge core_clk_i);
		#1;
		chk({7'h00, irq_o}, {7'h00, exp}, "irq level");
	endtask : chk_irq

	task automatic cmp_pulse();
		irq_seen = 1'b0;
		@(posedge core_clk_i) #1;
		analog_comparator_output_i = 1'b1;
		repeat (6) @(posedge core_clk_i);
		#1;
		analog_comparator_output_i = 1'b0;
		repeat (3) @(posedge core_clk_i);
	endtask : cmp_pulse

	task automatic t_regs();
		for (int a = 8'h90; a <= 8'h95; a++) rd(8'(a), 8'h00, "reset value");
		wr(8'h90, 8'hAA);
		rd(8'h90, 8'h00, "unmapped read");
		// Unused control bit reads zero
		wr(art_pkg::ADDR_CTRL, 8'hFF);
		rd(art_pkg::ADDR_CTRL, 8'hFD, "ctrl rw");
		wr(art_pkg::ADDR_CTRL, 8'h00);
		rd(art_pkg::ADDR_CTRL, 8'h00, "flags cleared");
	endtask : t_regs

	task automatic t_wide();
		wr(art_pkg::ADDR_RELOAD_L, 8'h34);
		wr(art_pkg::ADDR_RELOAD_H, 8'h12);
		wr(art_pkg::ADDR_COUNT_L, 8'hFE);
		wr(art_pkg::ADDR_COUNT_H, 8'hFF);
		wr(art_pkg::ADDR_CTRL, 8'h04);
		tick(0);
		rd(art_pkg::ADDR_CTRL, 8'h04, "no flag before wrap");
		// Full wrap reloads both bytes
		tick(0);
		rd(art_pkg::ADDR_COUNT_L, 8'h34, "reload low");
		rd(art_pkg::ADDR_COUNT_H, 8'h12, "reload high");
		rd(art_pkg::ADDR_CTRL, 8'hC4, "both flags");
		chk_irq(1'b1);
		// Run cleared stops counting
		wr(art_pkg::ADDR_CTRL, 8'h00);
		tick(0);
		rd(art_pkg::ADDR_COUNT_L, 8'h34, "stopped");
		chk_irq(1'b0);
		// Low wrap carries into high
		wr(art_pkg::ADDR_COUNT_L, 8'hFF);
		wr(art_pkg::ADDR_CTRL, 8'h04);
		tick(0);
		rd(art_pkg::ADDR_COUNT_L, 8'h00, "carry low");
		rd(art_pkg::ADDR_COUNT_H, 8'h13, "carry high");
		rd(art_pkg::ADDR_CTRL, 8'h44, "low flag only");
		chk_irq(1'b0);
	endtask : t_wide

	task automatic t_split();
		wr(art_pkg::ADDR_CTRL, 8'h00);
		wr(art_pkg::ADDR_RELOAD_L, 8'h80);
		wr(art_pkg::ADDR_RELOAD_H, 8'h70);
		wr(art_pkg::ADDR_COUNT_L, 8'hFF);
		wr(art_pkg::ADDR_COUNT_H, 8'hFF);
		wr(art_pkg::ADDR_CTRL, 8'h28);
		// Low byte counts with run cleared
		tick(0);
		rd(art_pkg::ADDR_COUNT_L, 8'h80, "split low reload");
		rd(art_pkg::ADDR_COUNT_H, 8'hFF, "split high held");
		rd(art_pkg::ADDR_CTRL, 8'h68, "split low flag");
		chk_irq(1'b1);
		wr(art_pkg::ADDR_CTRL, 8'h2C);
		tick(0);
		rd(art_pkg::ADDR_COUNT_L, 8'h81, "split low no carry");
		rd(art_pkg::ADDR_COUNT_H, 8'h70, "split high reload");
		rd(art_pkg::ADDR_CTRL, 8'hAC, "split high flag");
		// Global timer enable low masks the pending flags
		timer_irq_en_i = 1'b0;
		chk_irq(1'b0);
		timer_irq_en_i = 1'b1;
		chk_irq(1'b1);
	endtask : t_split

	task automatic t_ext();
		wr(art_pkg::ADDR_CTRL, 8'h05);
		wr(art_pkg::ADDR_COUNT_L, 8'h10);
		tick(0);
		rd(art_pkg::ADDR_COUNT_L, 8'h10, "system tick ignored");
		tick(1);
		rd(art_pkg::ADDR_COUNT_L, 8'h11, "external tick");
	endtask : t_ext

	task automatic t_capture();
		wr(art_pkg::ADDR_CTRL, 8'h00);
		wr(art_pkg::ADDR_COUNT_L, 8'h5A);
		wr(art_pkg::ADDR_COUNT_H, 8'hA5);
		wr(art_pkg::ADDR_CTRL, 8'h10);
		cmp_pulse();
		chk({7'h00, irq_seen}, 8'h01, "capture irq");
		rd(art_pkg::ADDR_RELOAD_L, 8'h5A, "capture low");
		rd(art_pkg::ADDR_RELOAD_H, 8'hA5, "capture high");
		// Disabled capture leaves reload alone
		wr(art_pkg::ADDR_CTRL, 8'h00);
		wr(art_pkg::ADDR_RELOAD_L, 8'h11);
		cmp_pulse();
		chk({7'h00, irq_seen}, 8'h00, "no capture irq");
		rd(art_pkg::ADDR_RELOAD_L, 8'h11, "no capture");
		// Capture still copies with timer interrupts masked, but raises no request
		wr(art_pkg::ADDR_CTRL, 8'h10);
		timer_irq_en_i = 1'b0;
		cmp_pulse();
		chk({7'h00, irq_seen}, 8'h00, "masked capture irq");
		rd(art_pkg::ADDR_RELOAD_L, 8'h5A, "masked capture low");
		timer_irq_en_i = 1'b1;
	endtask : t_capture

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (4) @(posedge core_clk_i);
		#1;
		rst_n_i        = 1'b1;
		timer_irq_en_i = 1'b1;
		t_regs();
		t_wide();
		t_split();
		t_ext();
		t_capture();
		end_of_test();
	end
endmodule : tb
